// ### cgtm_map.svh
// Purpose: offsets, field positions, reset values of the clock generator
//          trim and monitor register slice
// Assumes: 4-bit byte offsets on the plain register port
// Notes:   definitions only
`ifndef CGTM_MAP_SVH
`define CGTM_MAP_SVH

// ============================================================
// offsets
`define CGTM_OFF_IRQ_STATUS   4'h0
`define CGTM_OFF_IRQ_MASK     4'h1
`define CGTM_OFF_MON_CTRL     4'h2
`define CGTM_OFF_STATUS_TRIM  4'h8
`define CGTM_OFF_TRIM_CMP_HI  4'hA
`define CGTM_OFF_TRIM_CMP_LO  4'hB
`define CGTM_OFF_CTRL_SEVEN   4'hC
`define CGTM_OFF_LOCK_CTRL    4'hD
`define CGTM_OFF_CTRL_NINE    4'hE
`define CGTM_OFF_CTRL_TEN     4'hF

// ============================================================
// status_and_trim_control fields
`define CGTM_SC_TRIM_EN       7
`define CGTM_SC_TRIM_SEL      6
`define CGTM_SC_TRIM_FAIL     5
`define CGTM_SC_FLT_PRSRV     4
`define CGTM_SC_DIV_HI        3
`define CGTM_SC_DIV_LO        1
`define CGTM_SC_OSC_LOSS      0
`define CGTM_SC_RESET         8'h02

// ============================================================
// lock_loss_control, monitor control, interrupt bits, trim compare reset
`define CGTM_LC_RESET_SEL     6
`define CGTM_LC_RESET         8'h00
`define CGTM_MC_CLK_MON_EN    0
`define CGTM_MC_LOCK_INT_EN   1
`define CGTM_MC_RESET         8'h00
`define CGTM_IRQ_OSC_LOSS     0
`define CGTM_IRQ_LOCK_LOSS    1
`define CGTM_IRQ_TRIM_FAIL    2
`define CGTM_IRQ_BITS         3
`define CGTM_CMP_RESET        8'h00

`endif

// ### cgtm_pkg.sv
// Purpose: shared types of the clock generator trim and monitor slice
// Assumes: constants live in cgtm_map.svh
// Notes:   types only
`default_nettype none

package cgtm_pkg;
	typedef logic [7:0] cgtm_byte_t;
	typedef logic [3:0] cgtm_addr_t;
	typedef logic [2:0] cgtm_div_t;
endpackage : cgtm_pkg

`default_nettype wire

// ### cgtm_ref_div.sv
// Purpose: power-of-two divider of the fast internal reference tick
// Assumes: i_tick is a one-cycle enable on i_clk_sys
// Notes:   select 0 passes every tick, select 7 keeps one of 128
`timescale 1ns/100ps
`default_nettype none

module cgtm_ref_div (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_resetn,
	// control
	input  wire logic             i_tick,
	input  wire cgtm_pkg::cgtm_div_t i_div_sel,
	// divided enable
	output var  logic             o_tick
);

	logic [7:0] factor;
	logic [6:0] mask;
	logic [6:0] cnt_reg;

	// factor doubles with each step of the select
	assign factor = 8'h01 << i_div_sel;
	assign mask   = 7'(factor - 8'h01);

	// ============================================================
	// counter and pulse
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_reg <= 7'h00;
			o_tick  <= 1'b0;
		end else begin
			o_tick <= 1'b0;
			if (i_tick) begin
				if ((cnt_reg & mask) == mask) begin
					cnt_reg <= 7'h00;
					o_tick  <= 1'b1;
				end else begin
					cnt_reg <= 7'(cnt_reg + 7'h01);
				end
			end
		end
	end

endmodule : cgtm_ref_div

`default_nettype wire

// ### cgtm_regs.sv
// Purpose: trim and monitor register slice of the clock generator
// Assumes: one clock, plain register port with read data one cycle later
// Notes:   loss inputs come from other clock domains and are synchronised
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "cgtm_map.svh"

module cgtm_regs (
	// clock and reset
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_resetn,
	// register port
	input  wire cgtm_pkg::cgtm_addr_t i_addr,
	input  wire cgtm_pkg::cgtm_byte_t i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output var  cgtm_pkg::cgtm_byte_t o_rdata,
	// events from the clock engines
	input  wire logic                 i_osc_loss,
	input  wire logic                 i_pll_lock_loss,
	input  wire logic                 i_trim_done,
	input  wire logic                 i_stop_mode,
	input  wire logic                 i_other_ctrl_write,
	input  wire logic                 i_fast_ref_tick,
	// controls to the clock engines
	output var  cgtm_pkg::cgtm_div_t  o_fast_ref_divider,
	output var  logic                 o_fast_ref_tick,
	output var  logic                 o_osc_clock_monitor_enable,
	output var  logic                 o_trim_machine_enable,
	output var  logic                 o_trim_machine_select,
	output var  logic [15:0]          o_trim_compare,
	output var  logic                 o_fll_filter_preserve,
	output var  logic                 o_lock_loss_reset_req,
	output var  logic                 o_irq
);

	cgtm_pkg::cgtm_byte_t sc_reg;
	cgtm_pkg::cgtm_byte_t cmp_hi_reg;
	cgtm_pkg::cgtm_byte_t cmp_lo_reg;
	logic                 reset_sel_reg;
	logic                 mon_en_reg;
	logic                 lock_int_en_reg;
	logic [`CGTM_IRQ_BITS-1:0] irq_status_reg;
	logic [`CGTM_IRQ_BITS-1:0] irq_mask_reg;
	logic [`CGTM_IRQ_BITS-1:0] irq_set;
	logic [1:0]           osc_sync_reg;
	logic [1:0]           lock_sync_reg;
	logic                 lock_seen_reg;
	logic                 lock_event;
	logic                 osc_event;
	logic                 wr_sc;
	logic                 trim_abort;
	cgtm_pkg::cgtm_byte_t rdata_next;

	// ============================================================
	// input synchronisers
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			osc_sync_reg  <= 2'h0;
			lock_sync_reg <= 2'h0;
			lock_seen_reg <= 1'b0;
		end else begin
			osc_sync_reg  <= {osc_sync_reg[0], i_osc_loss};
			lock_sync_reg <= {lock_sync_reg[0], i_pll_lock_loss};
			lock_seen_reg <= lock_sync_reg[1];
		end
	end

	assign osc_event  = osc_sync_reg[1] & mon_en_reg;
	assign lock_event = lock_sync_reg[1] & ~lock_seen_reg;
	assign wr_sc      = i_wr && (i_addr == `CGTM_OFF_STATUS_TRIM);
	// a running trim is aborted by control writes or stop entry
	assign trim_abort = sc_reg[`CGTM_SC_TRIM_EN]
		& (wr_sc | i_other_ctrl_write | i_stop_mode);

	// ============================================================
	// status and trim control
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			sc_reg <= `CGTM_SC_RESET;
		end else begin
			if (wr_sc) begin
				sc_reg[`CGTM_SC_TRIM_SEL] <= i_wdata[`CGTM_SC_TRIM_SEL];
				sc_reg[`CGTM_SC_FLT_PRSRV] <= i_wdata[`CGTM_SC_FLT_PRSRV];
				sc_reg[`CGTM_SC_DIV_HI:`CGTM_SC_DIV_LO] <=
					i_wdata[`CGTM_SC_DIV_HI:`CGTM_SC_DIV_LO];
			end
			// trim enable: set by write, cleared by done or abort
			if (trim_abort || i_trim_done) begin
				sc_reg[`CGTM_SC_TRIM_EN] <= 1'b0;
			end else if (wr_sc) begin
				sc_reg[`CGTM_SC_TRIM_EN] <= i_wdata[`CGTM_SC_TRIM_EN];
			end
			// fail flag: abort sets, any write clears, set wins
			if (trim_abort) begin
				sc_reg[`CGTM_SC_TRIM_FAIL] <= 1'b1;
			end else if (wr_sc) begin
				sc_reg[`CGTM_SC_TRIM_FAIL] <= 1'b0;
			end
			// loss flag: write one clears, zero keeps, set wins
			if (osc_event) begin
				sc_reg[`CGTM_SC_OSC_LOSS] <= 1'b1;
			end else if (wr_sc && i_wdata[`CGTM_SC_OSC_LOSS]) begin
				sc_reg[`CGTM_SC_OSC_LOSS] <= 1'b0;
			end
		end
	end

	// ============================================================
	// trim compare, lock control, monitor control
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cmp_hi_reg      <= `CGTM_CMP_RESET;
			cmp_lo_reg      <= `CGTM_CMP_RESET;
			reset_sel_reg   <= 1'b0;
			mon_en_reg      <= 1'b0;
			lock_int_en_reg <= 1'b0;
		end else if (i_wr) begin
			case (i_addr)
				`CGTM_OFF_TRIM_CMP_HI: begin
					cmp_hi_reg <= i_wdata;
				end
				`CGTM_OFF_TRIM_CMP_LO: begin
					cmp_lo_reg <= i_wdata;
				end
				`CGTM_OFF_LOCK_CTRL: begin
					reset_sel_reg <= i_wdata[`CGTM_LC_RESET_SEL];
				end
				`CGTM_OFF_MON_CTRL: begin
					mon_en_reg      <= i_wdata[`CGTM_MC_CLK_MON_EN];
					lock_int_en_reg <= i_wdata[`CGTM_MC_LOCK_INT_EN];
				end
				default: begin
				end
			endcase
		end
	end

	// ============================================================
	// lock loss response
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_lock_loss_reset_req <= 1'b0;
		end else begin
			o_lock_loss_reset_req <= lock_event & reset_sel_reg;
		end
	end

	// ============================================================
	// interrupt status, mask and output
	assign irq_set[`CGTM_IRQ_OSC_LOSS]  = osc_event & ~sc_reg[`CGTM_SC_OSC_LOSS];
	assign irq_set[`CGTM_IRQ_LOCK_LOSS] = lock_event & ~reset_sel_reg
		& lock_int_en_reg;
	assign irq_set[`CGTM_IRQ_TRIM_FAIL] = trim_abort;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_status_reg <= '0;
			irq_mask_reg   <= '0;
			o_irq          <= 1'b0;
		end else begin
			if (i_wr && (i_addr == `CGTM_OFF_IRQ_STATUS)) begin
				irq_status_reg <= (irq_status_reg
					& ~i_wdata[`CGTM_IRQ_BITS-1:0]) | irq_set;
			end else begin
				irq_status_reg <= irq_status_reg | irq_set;
			end
			if (i_wr && (i_addr == `CGTM_OFF_IRQ_MASK)) begin
				irq_mask_reg <= i_wdata[`CGTM_IRQ_BITS-1:0];
			end
			o_irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// ============================================================
	// read path, one cycle latency, zero outside the answer cycle
	always_comb begin
		rdata_next = 8'h00;
		case (i_addr)
			`CGTM_OFF_IRQ_STATUS:  rdata_next = {5'h00, irq_status_reg};
			`CGTM_OFF_IRQ_MASK:    rdata_next = {5'h00, irq_mask_reg};
			`CGTM_OFF_MON_CTRL:    rdata_next = {6'h00, lock_int_en_reg,
				mon_en_reg};
			`CGTM_OFF_STATUS_TRIM: rdata_next = sc_reg;
			`CGTM_OFF_TRIM_CMP_HI: rdata_next = cmp_hi_reg;
			`CGTM_OFF_TRIM_CMP_LO: rdata_next = cmp_lo_reg;
			`CGTM_OFF_LOCK_CTRL:   rdata_next = {1'b0, reset_sel_reg,
				6'h00};
			default:               rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rdata_next : 8'h00;
		end
	end

	// ============================================================
	// control outputs, all from registers
	assign o_fast_ref_divider =
		sc_reg[`CGTM_SC_DIV_HI:`CGTM_SC_DIV_LO];
	assign o_osc_clock_monitor_enable = mon_en_reg;
	assign o_trim_machine_enable = sc_reg[`CGTM_SC_TRIM_EN];
	assign o_trim_machine_select = sc_reg[`CGTM_SC_TRIM_SEL];
	assign o_trim_compare = {cmp_hi_reg, cmp_lo_reg};
	assign o_fll_filter_preserve = sc_reg[`CGTM_SC_FLT_PRSRV];

	cgtm_ref_div u_ref_div (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_tick    (i_fast_ref_tick),
		.i_div_sel (sc_reg[`CGTM_SC_DIV_HI:`CGTM_SC_DIV_LO]),
		.o_tick    (o_fast_ref_tick)
	);

endmodule : cgtm_regs

`default_nettype wire

// ### cgtm_regs_monitor.sv
// Purpose: concurrent checks on the trim and monitor register slice
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to cgtm_regs below
`timescale 1ns/100ps
`default_nettype none

module cgtm_regs_monitor (
	input wire logic                 i_clk_sys,
	input wire logic                 i_resetn,
	input wire cgtm_pkg::cgtm_addr_t i_addr,
	input wire cgtm_pkg::cgtm_byte_t i_wdata,
	input wire logic                 i_wr,
	input wire logic                 i_rd,
	input wire cgtm_pkg::cgtm_byte_t o_rdata,
	input wire logic                 i_pll_lock_loss,
	input wire logic                 i_trim_done,
	input wire logic                 i_stop_mode,
	input wire logic                 i_other_ctrl_write,
	input wire cgtm_pkg::cgtm_div_t  o_fast_ref_divider,
	input wire logic                 o_trim_machine_enable,
	input wire logic [15:0]          o_trim_compare,
	input wire logic                 o_lock_loss_reset_req
);
	// ====
	// shadow of the lock-loss response select
	logic sel_reg;
	logic [7:0] cmp_lo;
	assign cmp_lo = o_trim_compare[7:0];
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_reg <= 1'b0;
		end else if (i_wr && i_addr == 4'hD) begin
			sel_reg <= i_wdata[6];
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	// ====
	// properties
	a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_reserved_reads_zero: assert property (i_rd && i_addr inside {4'h3, 4'h4,
		4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hE, 4'hF} |=> o_rdata == 8'h00)
		else $error("reserved offset read not zero");
	a_cmp_low_read: assert property (i_rd && i_addr == 4'hB |=>
		o_rdata == $past(cmp_lo)) else $error("low compare read wrong");
	a_cmp_high_write: assert property (i_wr && i_addr == 4'hA |=>
		o_trim_compare[15:8] == $past(i_wdata)) else $error("high compare bad");
	a_divider_read: assert property (i_rd && i_addr == 4'h8 |=>
		o_rdata[3:1] == $past(o_fast_ref_divider)) else $error("divider read");
	a_req_one_cycle: assert property (o_lock_loss_reset_req |=>
		!o_lock_loss_reset_req) else $error("reset request too long");
	a_req_needs_select: assert property (o_lock_loss_reset_req |->
		$past(sel_reg)) else $error("reset request with select clear");
	a_lock_reset_time: assert property ($rose(i_pll_lock_loss) && sel_reg
		|-> ##[2:5] o_lock_loss_reset_req) else $error("no reset request");
	a_trim_abort_clear: assert property (o_trim_machine_enable &&
		(i_trim_done || i_stop_mode || i_other_ctrl_write ||
		(i_wr && i_addr == 4'h8)) |=> !o_trim_machine_enable)
		else $error("trim enable not cleared");
endmodule : cgtm_regs_monitor

bind cgtm_regs cgtm_regs_monitor cgtm_regs_monitor_inst (
	.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_pll_lock_loss(i_pll_lock_loss), .i_trim_done(i_trim_done),
	.i_stop_mode(i_stop_mode), .i_other_ctrl_write(i_other_ctrl_write),
	.o_fast_ref_divider(o_fast_ref_divider),
	.o_trim_machine_enable(o_trim_machine_enable),
	.o_trim_compare(o_trim_compare),
	.o_lock_loss_reset_req(o_lock_loss_reset_req));

`default_nettype wire

// ### cgtm_regs_tb.sv
// Purpose: directed register tests of the trim and monitor slice
// Assumes: 200 MHz clock, reset held 12 cycles
// Notes:   read data checked one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none

module cgtm_regs_tb;
	logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic osc = 1'b0, pll = 1'b0, done = 1'b0, stop = 1'b0, other = 1'b0;
	logic tick = 1'b0, ftick, mon, te, ts, flt, req, irq;
	cgtm_pkg::cgtm_addr_t i_addr = 4'h0;
	cgtm_pkg::cgtm_byte_t i_wdata = 8'h00, o_rdata;
	cgtm_pkg::cgtm_div_t  div;
	logic [15:0]          cmp;
	int errors = 0, comparisons = 0, ticks = 0, seen;
	cgtm_pkg::cgtm_addr_t rs[9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9,
		4'hC, 4'hE, 4'hF};
	always #2.5 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) if (ftick === 1'b1) ticks++;
	cgtm_regs cgtm_regs_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_osc_loss(osc), .i_pll_lock_loss(pll),
		.i_trim_done(done), .i_stop_mode(stop), .i_other_ctrl_write(other),
		.i_fast_ref_tick(tick), .o_fast_ref_divider(div),
		.o_fast_ref_tick(ftick), .o_osc_clock_monitor_enable(mon),
		.o_trim_machine_enable(te), .o_trim_machine_select(ts),
		.o_trim_compare(cmp), .o_fll_filter_preserve(flt),
		.o_lock_loss_reset_req(req), .o_irq(irq));
	// ====
	// access tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		cyc(1);
		i_wr <= 1'b0;
		// one idle edge so a following call never reassigns the strobe
		cyc(1);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		cyc(1);
		i_rd <= 1'b0;
		chk({8'h00, o_rdata}, {8'h00, e});
		cyc(1);
	endtask : rd
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		cyc(20000);
		errors++;
		report_and_stop();
	end
	// ====
	// tests
	initial begin
		cyc(12);
		i_resetn <= 1'b1;
		rd(4'h8, 8'h02);
		rd(4'hB, 8'h00);
		wr(4'hA, 8'h5A);
		wr(4'hB, 8'hA5);
		rd(4'hB, 8'hA5);
		chk(cmp, 16'h5AA5);
		foreach (rs[i]) begin
			wr(rs[i], 8'hFF);
			rd(rs[i], 8'h00);
		end
		wr(4'hD, 8'hFF);
		rd(4'hD, 8'h40);
		for (int d = 0; d < 8; d++) begin
			wr(4'h8, 8'(d << 1));
			chk(16'(div), 16'(d));
			ticks = 0;
			repeat (256) begin
				tick <= 1'b1;
				cyc(1);
				tick <= 1'b0;
				cyc(1);
			end
			cyc(3);
			chk(16'(ticks >= (256 >> d) && ticks <= (256 >> d) + 1), 16'h0001);
		end
		wr(4'h8, 8'h31);
		rd(4'h8, 8'h10);
		chk(16'(flt), 16'h0001);
		wr(4'h8, 8'h00);
		wr(4'h1, 8'h07);
		for (int m = 0; m < 2; m++) begin
			wr(4'h2, 8'(m));
			chk(16'(mon), 16'(m));
			osc <= 1'b1;
			cyc(6);
			osc <= 1'b0;
			cyc(4);
			rd(4'h8, 8'(m));
		end
		chk(16'(irq), 16'h0001);
		wr(4'h8, 8'h00);
		rd(4'h8, 8'h01);
		wr(4'h8, 8'h01);
		rd(4'h8, 8'h00);
		wr(4'h0, 8'h01);
		wr(4'h2, 8'h03);
		rd(4'h0, 8'h00);
		wr(4'hD, 8'h00);
		pll <= 1'b1;
		cyc(6);
		rd(4'h0, 8'h02);
		chk(16'(irq), 16'h0001);
		pll <= 1'b0;
		wr(4'h0, 8'hFF);
		wr(4'hD, 8'h40);
		pll <= 1'b1;
		seen = 0;
		repeat (8) begin
			cyc(1);
			if (req === 1'b1) seen++;
		end
		chk(16'(seen), 16'h0001);
		rd(4'h0, 8'h00);
		pll <= 1'b0;
		wr(4'h8, 8'hC0);
		chk({te, ts}, 16'h0003);
		done <= 1'b1;
		cyc(1);
		done <= 1'b0;
		rd(4'h8, 8'h40);
		for (int k = 0; k < 3; k++) begin
			wr(4'h8, 8'h80);
			stop <= (k == 0);
			other <= (k == 1);
			if (k == 2) wr(4'h8, 8'h00);
			else cyc(1);
			stop <= 1'b0;
			other <= 1'b0;
			rd(4'h8, 8'h20);
			rd(4'h0, 8'h04);
			wr(4'h0, 8'h04);
		end
		cyc(2);
		chk(16'(irq), 16'h0000);
		report_and_stop();
	end
endmodule : cgtm_regs_tb

`default_nettype wire
